// >>> rtl/iefb_consts.vh
`ifndef IEFB_CONSTS_VH
`define IEFB_CONSTS_VH
// register byte addresses (9-bit data address space)
`define IEFB_ADDR_W 9
`define IEFB_ADDR_CTRL_B0 9'h00b
`define IEFB_ADDR_CTRL_B1 9'h08b
`define IEFB_ADDR_PIE 9'h08c
`define IEFB_ADDR_ISTAT 9'h0f0
`define IEFB_ADDR_IMASK 9'h0f1
// control register fields
`define IEFB_CTL_GIE_BIT 7
`define IEFB_CTL_PGE_BIT 6
`define IEFB_CTL_T0E_BIT 5
`define IEFB_CTL_EXE_BIT 4
`define IEFB_CTL_PBE_BIT 3
`define IEFB_CTL_T0F_BIT 2
`define IEFB_CTL_EXF_BIT 1
`define IEFB_CTL_PBF_BIT 0
// peripheral enable: bit 3 unimplemented
`define IEFB_PIE_MASK 8'hf7
`define IEFB_PIE_RST 8'h00
`define IEFB_CTL_RST 7'h00
// reset value of the five enable bits 7 to 3 of the control register
`define IEFB_CTL_EN_RST 5'h00
// event status bits
`define IEFB_EV_W 3
`define IEFB_EV_RST 3'h0
`endif

// >>> rtl/iefb_edge.v
// change detector on already synchronised bits
module iefb_edge #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire core_clk_in,
    input wire srst_in,
    // sampled level and edge pulses
    input wire [WIDTH-1:0] level_in,
    output wire [WIDTH-1:0] rise_out,
    output wire [WIDTH-1:0] fall_out
);
    reg [WIDTH-1:0] prev_q;

    // prev follows level; reset to level would need a port value, so use zero
    // and let the owner ignore the first four cycles after reset
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            prev_q <= {WIDTH{1'b0}};
        end else begin
            prev_q <= level_in;
        end
    end

    assign rise_out = level_in & ~prev_q;
    assign fall_out = ~level_in & prev_q;
endmodule

// >>> rtl/iefb_irq_bank.v
// The plain strobed port was decided locally.
`include "iefb_consts.vh"
// Function
// [R1] the control register answers at both bank addresses and both reach one storage.
// [R2] control bit 7 is the global enable and with it clear no request reaches the cpu.
// [R3] control bit 2 sets on a timer0 overflow and holds until software writes it zero.
// [R4] control bit 1 sets on an external pin event and holds until software clears it.
// [R5] control bit 0 sets when any upper port-b pin changes and holds until written zero.
// [R6] reset clears control bits 7 to 1 and leaves the port-change flag undefined.
// [R7] the peripheral enable register sits at one address in the second bank only.
// [R8] the peripheral enable register holds seven source enables, all cleared at reset.
// [R9] peripheral enable bit 3 is unimplemented, reads zero and ignores writes.
// [R10] every flag sets on its condition regardless of its enable and the global enable.
// [R11] the pin flag follows a rising edge when edge select is one, else a falling edge.
// [R12] each peripheral enable pairs with the same bit of the peripheral flag register.
// [R13] control bits 6 to 3 are peripheral group, timer0, pin and port-change enables.
// [R14] the request needs the global enable and an enabled core flag or peripheral flag.
module iefb_irq_bank (
    // clock and reset
    input wire core_clk_in,
    input wire srst_in,
    // register port
    input wire [`IEFB_ADDR_W-1:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    // event sources
    input wire timer0_overflow_in,
    input wire ext_irq_pin_in,
    input wire [3:0] portb_upper_pins_in,
    input wire ext_edge_select_in,
    input wire [7:0] peripheral_irq_flags_in,
    // interrupt outputs
    output reg cpu_irq_req_out,
    output reg evt_irq_out
);
    // ****************************************************************
    // synchronisers and edge detection
    // ****************************************************************
    wire ext_pin_s;
    wire [3:0] portb_s;
    wire ext_rise;
    wire ext_fall;
    wire [3:0] pb_rise;
    wire [3:0] pb_fall;
    reg edge_armed_q;

    iefb_sync2 #(
        .WIDTH(5)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .async_in({ext_irq_pin_in, portb_upper_pins_in}),
        .sync_out({ext_pin_s, portb_s})
    );

    iefb_edge #(
        .WIDTH(5)
    ) u_edge (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .level_in({ext_pin_s, portb_s}),
        .rise_out({ext_rise, pb_rise}),
        .fall_out({ext_fall, pb_fall})
    );

    // edge history is meaningless until the sync chain has filled
    reg [1:0] arm_cnt_q;
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            arm_cnt_q <= 2'h0;
            edge_armed_q <= 1'b0;
        end else begin
            if (arm_cnt_q != 2'h3) begin
                arm_cnt_q <= arm_cnt_q + 2'h1;
            end
            edge_armed_q <= (arm_cnt_q == 2'h3);
        end
    end

    // edge select is a same-domain level from the option register
    wire ext_event = edge_armed_q &
        (ext_edge_select_in ? ext_rise : ext_fall); // [R11]
    wire pb_event = edge_armed_q & (|(pb_rise | pb_fall)); // [R5]

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire hit_ctrl = (reg_addr_in == `IEFB_ADDR_CTRL_B0) ||
        (reg_addr_in == `IEFB_ADDR_CTRL_B1); // [R1]
    wire hit_pie = (reg_addr_in == `IEFB_ADDR_PIE); // [R7]
    wire hit_stat = (reg_addr_in == `IEFB_ADDR_ISTAT);
    wire hit_mask = (reg_addr_in == `IEFB_ADDR_IMASK);
    wire wr_ctrl = reg_wr_in & hit_ctrl;

    // ****************************************************************
    // control register
    // ****************************************************************
    reg [7:3] ctl_en_q;
    reg t0_flag_q;
    reg ext_flag_q;
    reg pb_flag_q;
    reg [7:3] ctl_en_d;
    reg t0_flag_d;
    reg ext_flag_d;
    reg pb_flag_d;

    // a write lands first, then a same-cycle event sets over it, so no event is lost
    always @* begin
        ctl_en_d = ctl_en_q;
        t0_flag_d = t0_flag_q;
        ext_flag_d = ext_flag_q;
        pb_flag_d = pb_flag_q;
        if (wr_ctrl) begin
            ctl_en_d = reg_wdata_in[7:3]; // [R13]
            t0_flag_d = reg_wdata_in[`IEFB_CTL_T0F_BIT];
            ext_flag_d = reg_wdata_in[`IEFB_CTL_EXF_BIT];
            pb_flag_d = reg_wdata_in[`IEFB_CTL_PBF_BIT];
        end
        if (timer0_overflow_in) begin
            t0_flag_d = 1'b1; // [R3] [R10]
        end
        if (ext_event) begin
            ext_flag_d = 1'b1; // [R4] [R10]
        end
        if (pb_event) begin
            pb_flag_d = 1'b1; // [R5] [R10]
        end
    end

    // port-change flag has no reset term: it powers up unknown
    always @(posedge core_clk_in) begin
        pb_flag_q <= pb_flag_d; // [R6]
        if (srst_in) begin
            ctl_en_q <= `IEFB_CTL_EN_RST; // [R6]
            t0_flag_q <= 1'b0;
            ext_flag_q <= 1'b0;
        end else begin
            ctl_en_q <= ctl_en_d;
            t0_flag_q <= t0_flag_d;
            ext_flag_q <= ext_flag_d;
        end
    end

    wire [7:0] ctl_rd = {ctl_en_q, t0_flag_q, ext_flag_q, pb_flag_q};

    // ****************************************************************
    // peripheral enable register
    // ****************************************************************
    reg [7:0] pie_q;
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            pie_q <= `IEFB_PIE_RST; // [R8]
        end else if (reg_wr_in && hit_pie) begin
            pie_q <= reg_wdata_in & `IEFB_PIE_MASK; // [R9]
        end
    end

    // ****************************************************************
    // event status (sticky, write one to clear) and mask (plain write)
    // ****************************************************************
    reg [`IEFB_EV_W-1:0] ev_stat_q;
    reg [`IEFB_EV_W-1:0] ev_mask_q;
    wire [`IEFB_EV_W-1:0] ev_set = {timer0_overflow_in, ext_event, pb_event};
    wire [`IEFB_EV_W-1:0] ev_clr = (reg_wr_in && hit_stat) ?
        reg_wdata_in[`IEFB_EV_W-1:0] : `IEFB_EV_RST;

    // set beats clear in the same cycle
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            ev_stat_q <= `IEFB_EV_RST;
            ev_mask_q <= `IEFB_EV_RST;
        end else begin
            ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
            if (reg_wr_in && hit_mask) begin
                ev_mask_q <= reg_wdata_in[`IEFB_EV_W-1:0];
            end
        end
    end

    // ****************************************************************
    // request combine
    // ****************************************************************
    // peripheral flags come from same-clock logic, no sync needed
    wire core_req = (ctl_en_q[`IEFB_CTL_T0E_BIT] & t0_flag_q) |
        (ctl_en_q[`IEFB_CTL_EXE_BIT] & ext_flag_q) |
        (ctl_en_q[`IEFB_CTL_PBE_BIT] & pb_flag_q === 1'b1); // [R13]
    wire peri_req = ctl_en_q[`IEFB_CTL_PGE_BIT] &
        (|(pie_q & peripheral_irq_flags_in & `IEFB_PIE_MASK)); // [R12]

    // registered so the cpu sees a glitch-free level, one cycle late
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            cpu_irq_req_out <= 1'b0;
            evt_irq_out <= 1'b0;
        end else begin
            cpu_irq_req_out <= ctl_en_q[`IEFB_CTL_GIE_BIT] &
                (core_req | peri_req); // [R2] [R14]
            evt_irq_out <= |(ev_stat_q & ev_mask_q);
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    // unmapped addresses read zero; data valid only the cycle after the strobe
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            if (hit_ctrl) begin
                reg_rdata_out <= ctl_rd;
            end else if (hit_pie) begin
                reg_rdata_out <= pie_q; // [R9]
            end else if (hit_stat) begin
                reg_rdata_out <= {5'h00, ev_stat_q};
            end else if (hit_mask) begin
                reg_rdata_out <= {5'h00, ev_mask_q};
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end
endmodule

// >>> rtl/iefb_sync2.v
// two-flop synchroniser, one per pin bit
module iefb_sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire core_clk_in,
    input wire srst_in,
    // async in, synced out
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            meta_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// >>> tb/iefb_irq_bank_monitor.sv
// ****************
// port checker
// ****************
module iefb_irq_bank_monitor (
    // clock and reset
    input wire core_clk_in,
    input wire srst_in,
    // register port
    input wire [8:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    // events and requests
    input wire timer0_overflow_in,
    input wire [7:0] peripheral_irq_flags_in,
    input wire cpu_irq_req_out,
    input wire evt_irq_out
);
    logic [7:0] ctl_q, pie_q;
    logic msk_q;
    // shadow of enables only; flags are judged by the bench
    always @(posedge core_clk_in) begin
        if (srst_in) begin
            ctl_q <= 8'h00;
            pie_q <= 8'h00;
            msk_q <= 1'b0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == 9'h00b || reg_addr_in == 9'h08b) ctl_q <= reg_wdata_in;
            if (reg_addr_in == 9'h08c) pie_q <= reg_wdata_in & 8'hf7;
            if (reg_addr_in == 9'h0f1) msk_q <= reg_wdata_in[2];
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    AST_RD_IDLE: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("rdata outside slot");
    AST_PIE_RD: assert property (
        $past(reg_rd_in) && $past(reg_addr_in) == 9'h08c |-> reg_rdata_out == $past(pie_q))
        else $error("enable read wrong");
    AST_HOLE: assert property (
        $past(reg_rd_in) && $past(reg_addr_in) == 9'h00c |-> reg_rdata_out == 8'h00)
        else $error("bank0 hole not zero");
    AST_RST_QUIET: assert property (
        $past(srst_in) |-> !cpu_irq_req_out && !evt_irq_out) else $error("irq after reset");
    AST_GIE_OFF: assert property (
        !ctl_q[7] |=> !cpu_irq_req_out) else $error("request without global enable");
    AST_T0_REQ: assert property (
        timer0_overflow_in && ctl_q[7] && ctl_q[5] && !reg_wr_in |-> ##2 cpu_irq_req_out)
        else $error("timer request missing");
    AST_T0_EVT: assert property (
        timer0_overflow_in && msk_q && !reg_wr_in |-> ##2 evt_irq_out) else $error("evt missing");
    AST_PERIPH: assert property (
        ctl_q[7] && ctl_q[6] && |(pie_q & peripheral_irq_flags_in) |=> cpu_irq_req_out)
        else $error("peripheral request missing");
endmodule
bind iefb_irq_bank iefb_irq_bank_monitor mon_u (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .timer0_overflow_in(timer0_overflow_in), .peripheral_irq_flags_in(peripheral_irq_flags_in),
    .cpu_irq_req_out(cpu_irq_req_out), .evt_irq_out(evt_irq_out));

// >>> tb/tb_iefb_irq_bank.sv
// ****************
// bench
// ****************
module tb_iefb_irq_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, t0 = 1'b0, pin = 1'b0, sel = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00, pflags = 8'h00, rdata, v, w;
    logic [3:0] pb = 4'h0;
    wire [7:0] rdo;
    wire irq, evt;
    integer fails = 0, cmp_count = 0, seed = 32'h89bf, i;
    iefb_irq_bank dut_u (.core_clk_in(clk), .srst_in(srst), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdo),
        .timer0_overflow_in(t0), .ext_irq_pin_in(pin), .portb_upper_pins_in(pb),
        .ext_edge_select_in(sel), .peripheral_irq_flags_in(pflags),
        .cpu_irq_req_out(irq), .evt_irq_out(evt));
    initial forever #4 clk = ~clk;
    // expected request from written enables and peripheral flags, core flags clear
    function logic exp_irq(input logic [7:0] c, input logic [7:0] p, input logic [7:0] f);
        return c[7] & c[6] & (|(p & f & 8'hf7));
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    // data sampled just after the edge that ends the strobe, its only valid cycle
    task rd(input logic [8:0] a);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 rdata = rdo;
    endtask
    task pulse;
        @(posedge clk);
        t0 <= 1'b1;
        @(posedge clk);
        t0 <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task stop_test;
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(9'h00b); chk(rdata & 8'hfe, 8'h00);
        rd(9'h08c); chk(rdata, 8'h00);
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            wr(9'h08c, v);
            rd(9'h08c); chk(rdata, v & 8'hf7);
            rd(9'h00c); chk(rdata, 8'h00);
            wr(9'h08b, v & 8'hf8);
            rd(9'h00b); chk(rdata, v & 8'hf8);
        end
        wr(9'h08c, 8'h00);
        wr(9'h00b, 8'h00);
        wr(9'h0f1, 8'h04);
        pulse; chk({7'h00, irq}, 8'h00);
        chk({7'h00, evt}, 8'h01);
        rd(9'h00b); chk(rdata, 8'h04);
        wr(9'h00b, 8'ha4); repeat (2) @(posedge clk); #1 chk({7'h00, irq}, 8'h01);
        wr(9'h0f0, 8'h04); repeat (2) @(posedge clk); #1 chk({7'h00, evt}, 8'h00);
        wr(9'h00b, 8'ha0); repeat (2) @(posedge clk); #1 chk({7'h00, irq}, 8'h00);
        pulse; chk({7'h00, irq}, 8'h01);
        // pin flag for each edge select, the opposite edge must stay quiet
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            sel <= i[0];
            pin <= ~i[0];
            wr(9'h00b, 8'h00); repeat (6) @(posedge clk);
            wr(9'h00b, 8'h00);
            pin <= i[0]; repeat (6) @(posedge clk);
            rd(9'h00b); chk(rdata, 8'h02);
            wr(9'h00b, 8'h00);
            pin <= ~i[0]; repeat (6) @(posedge clk);
            rd(9'h00b); chk(rdata, 8'h00);
        end
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(9'h00b, 8'h00);
            pb <= pb ^ (v[3:0] | 4'h1); repeat (6) @(posedge clk);
            rd(9'h00b); chk(rdata, 8'h01);
        end
        for (i = 0; i < 12; i++) begin
            v = $random(seed);
            w = $random(seed);
            wr(9'h08c, v);
            pflags <= w;
            wr(9'h00b, v & 8'hc0); repeat (2) @(posedge clk); #1;
            chk({7'h00, irq}, {7'h00, exp_irq(v & 8'hc0, v, w)});
        end
        stop_test;
    end
    initial begin
        #200000;
        fails++;
        stop_test;
    end
endmodule
